// file: inc/ptp_sync_map.svh
`ifndef PTP_SYNC_MAP_SVH
`define PTP_SYNC_MAP_SVH

// Register byte offsets.
`define REG_CTRL        8'h00
`define REG_LINK_DELAY  8'h04
`define REG_SSM_TX_EN   8'h08
`define REG_SSM_CAPABLE 8'h0C
`define REG_STATUS      8'h10
`define REG_QL_STATUS   8'h14
`define REG_RX_SSM      8'h18
`define REG_TC_COUNT    8'h1C
`define REG_SRC_BASE    8'h20
`define REG_SRC_LAST    8'h3C

// Control register fields.
`define CTRL_BC_MODE      0
`define CTRL_HOLD_NO_USE  1

// Source configuration fields.
`define SRC_QL_LSB  0
`define SRC_PRI_LSB 4
`define SRC_EN_BIT  8

// Quality codes, highest quality first.
`define QL_AUTO     4'h0
`define QL_G811     4'h1
`define QL_SSU_A    4'h2
`define QL_SSU_B    4'h3
`define QL_G813     4'h4
`define QL_PRS      4'h5
`define QL_ST2      4'h6
`define QL_TNC      4'h7
`define QL_ST3E     4'h8
`define QL_ST3      4'h9
`define QL_SMC      4'hA
`define QL_UNKNOWN  4'hB
`define QL_NO_USE   4'hC
`define QL_FAILURE  4'hD

// Reset values.
`define RST_SRC_CFG    9'h0BB
`define RST_SSM_TX_EN  8'hFF
`define RST_SSM_CAP    8'hFF
`define RST_LINK_DELAY 32'h0000_0000

// Multicast destination of generated PTP frames.
`define PTP_MCAST_MAC  48'h011B_1900_0000

// Timing: clock period and the per-cycle increment of the scaled time.
`define CLK_PERIOD_NS  8
`define TIME_INC       (64'(`CLK_PERIOD_NS) << 16)

`endif

// file: inc/ptp_sync_pkg.sv
package ptp_sync_pkg;

  typedef logic [3:0] ql_t;

  typedef struct packed {
    logic [3:0]  msg_type;
    logic [1:0]  port;
    logic [63:0] ingress_ts;
    logic [63:0] correction;
  } ptp_desc_t;

  typedef struct packed {
    logic       valid;
    logic [2:0] port;
    ql_t        ql;
  } ssm_rx_t;

  typedef struct packed {
    logic       valid;
    logic       lost;
    logic [1:0] port;
    logic [7:0] clock_class;
  } announce_t;

endpackage : ptp_sync_pkg

// file: sim/ptp_far_node.sv
`timescale 1ns/1ps
`default_nettype none
module ptp_far_node (
  input  wire logic  clk,
  input  wire logic  srst,
  input  wire logic  slow,
  input  wire logic  out_valid,
  output logic       out_ready,
  output logic [15:0] beats
);
  // A slow node takes a message only every other cycle.
  always_ff @(posedge clk) begin
    if (srst) begin
      out_ready <= 1'b1;
    end else begin
      out_ready <= slow ? !out_ready : 1'b1;
    end
  end
  // Counts every message that the node accepts.
  always_ff @(posedge clk) begin
    if (srst) begin
      beats <= 16'h0000;
    end else if (out_valid && out_ready) begin
      beats <= beats + 16'h0001;
    end
  end
endmodule : ptp_far_node
`default_nettype wire

// file: sim/ptp_sync_source_select_sva.sv
`timescale 1ns/1ps
`default_nettype none
module ptp_sync_source_select_sva (
  input wire logic                    REF_CLK,
  input wire logic                    SRST,
  input wire logic                    S_AXI_RVALID,
  input wire logic                    S_AXI_RREADY,
  input wire logic [31:0]             S_AXI_RDATA,
  input wire logic [7:0]              SRC_FAULT,
  input wire logic [7:0][3:0]         SSM_TX_QL,
  input wire logic [2:0]              REF_SEL,
  input wire logic                    REF_VALID,
  input wire logic                    PTP_IN_VALID,
  input wire logic                    PTP_IN_READY,
  input wire ptp_sync_pkg::ptp_desc_t PTP_IN,
  input wire logic                    PTP_OUT_VALID,
  input wire logic                    PTP_OUT_READY,
  input wire ptp_sync_pkg::ptp_desc_t PTP_OUT,
  input wire logic                    PTP_TERM_VALID,
  input wire logic [3:0]              BC_SLAVE_PORT,
  input wire logic [3:0]              BC_MASTER_PORTS,
  input wire logic                    BC_MCAST_EN,
  input wire logic [47:0]             BC_DEST_MAC
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (SRST);
  property p_out_hold;
    PTP_OUT_VALID && !PTP_OUT_READY |=> PTP_OUT_VALID && $stable(PTP_OUT);
  endproperty
  a_out_hold: assert property (p_out_hold) else $error("Output moved.");
  property p_pass;
    PTP_IN_VALID && PTP_IN_READY && PTP_IN.msg_type > 4'h1 && !BC_MCAST_EN
      |=> PTP_OUT_VALID && PTP_OUT == $past(PTP_IN);
  endproperty
  a_pass: assert property (p_pass) else $error("General passed bad.");
  property p_back_off;
    REF_VALID && $past(REF_VALID) && $stable(REF_SEL)
      |=> SSM_TX_QL[$past(REF_SEL)] == 4'hC;
  endproperty
  a_back_off: assert property (p_back_off) else $error("Loop guard.");
  property p_fault;
    REF_VALID && SRC_FAULT[REF_SEL] && $stable(SRC_FAULT)
      |=> !REF_VALID || !SRC_FAULT[REF_SEL];
  endproperty
  a_fault: assert property (p_fault) else $error("Failed kept.");
  property p_tc_idle;
    !BC_MCAST_EN && $past(!BC_MCAST_EN) |-> BC_SLAVE_PORT == 4'h0
      && BC_MASTER_PORTS == 4'h0 && !PTP_TERM_VALID;
  endproperty
  a_tc_idle: assert property (p_tc_idle) else $error("Role taken.");
  property p_one_slave;
    BC_SLAVE_PORT != 4'h0 |-> $onehot(BC_SLAVE_PORT)
      && (BC_SLAVE_PORT & BC_MASTER_PORTS) == 4'h0;
  endproperty
  a_one_slave: assert property (p_one_slave) else $error("Ports.");
  property p_term;
    PTP_TERM_VALID |-> !PTP_OUT_VALID && BC_SLAVE_PORT[PTP_OUT.port];
  endproperty
  a_term: assert property (p_term) else $error("Bad end.");
  property p_mcast;
    BC_MCAST_EN |-> BC_DEST_MAC[40];
  endproperty
  a_mcast: assert property (p_mcast) else $error("Not group.");
  property p_rd_hold;
    S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("Read moved.");
  c_term: cover property (PTP_TERM_VALID);
  c_stall: cover property (PTP_OUT_VALID && !PTP_OUT_READY);
  c_move: cover property (REF_VALID && !$stable(REF_SEL));
endmodule : ptp_sync_source_select_sva
bind ptp_sync_source_select ptp_sync_source_select_sva i_sva (.*);
`default_nettype wire

// file: sim/tb_ptp_sync_source_select.sv
`include "ptp_sync_map.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_ptp_sync_source_select;
  logic        REF_CLK, SRST, S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID;
  logic        S_AXI_WREADY, S_AXI_BVALID, S_AXI_BREADY, S_AXI_ARVALID;
  logic        S_AXI_ARREADY, S_AXI_RVALID, S_AXI_RREADY, REF_VALID;
  logic        PTP_IN_VALID, PTP_IN_READY, PTP_OUT_VALID, PTP_OUT_READY;
  logic        PTP_TERM_VALID, BC_MCAST_EN, bc, slow;
  logic [7:0]  S_AXI_AWADDR, S_AXI_ARADDR, SRC_FAULT, SRC_HOLDOVER, SSM_TX_EN;
  logic [31:0] S_AXI_WDATA, S_AXI_RDATA;
  logic [3:0]  S_AXI_WSTRB, BC_SLAVE_PORT, BC_MASTER_PORTS;
  logic [1:0]  S_AXI_BRESP, S_AXI_RRESP;
  logic [2:0]  REF_SEL;
  logic [47:0] BC_DEST_MAC;
  logic [63:0] cyc, link;
  logic [15:0] beats;
  logic [7:0][3:0]         SSM_TX_QL;
  ptp_sync_pkg::ssm_rx_t   SSM_RX;
  ptp_sync_pkg::announce_t ANNOUNCE;
  ptp_sync_pkg::ptp_desc_t PTP_IN, PTP_OUT, e;
  ptp_sync_pkg::ptp_desc_t exq[$];
  int          n_mismatch, check_count, nterm, i;

  ptp_sync_source_select i_dut (.*);
  ptp_far_node i_far (.clk(REF_CLK), .srst(SRST), .slow(slow),
    .out_valid(PTP_OUT_VALID), .out_ready(PTP_OUT_READY), .beats(beats));

  initial begin
    REF_CLK = 1'b0;
    forever #4 REF_CLK = ~REF_CLK;
  end

  task automatic close_out;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : close_out

  task automatic chk(input logic [135:0] s, input logic [135:0] x);
    check_count++;
    if (s !== x) begin
      n_mismatch++;
      $display("ERROR %0t: got %0h expected %0h", $time, s, x);
    end
  endtask : chk

  task automatic tmo(input int n);
    if (n >= 50) begin
      n_mismatch++;
      close_out;
    end
  endtask : tmo

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] r);
    int k;
    S_AXI_AWADDR <= a;
    S_AXI_WDATA <= d;
    S_AXI_AWVALID <= 1'b1;
    S_AXI_WVALID <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge REF_CLK);
      if (S_AXI_AWREADY && S_AXI_AWVALID) S_AXI_AWVALID <= 1'b0;
      if (S_AXI_WREADY && S_AXI_WVALID) S_AXI_WVALID <= 1'b0;
      if (S_AXI_BVALID) break;
    end
    tmo(k);
    chk(S_AXI_BRESP, r);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] x,
                    input logic [1:0] r);
    int k;
    S_AXI_ARADDR <= a;
    S_AXI_ARVALID <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge REF_CLK);
      if (S_AXI_ARREADY && S_AXI_ARVALID) S_AXI_ARVALID <= 1'b0;
      if (S_AXI_RVALID && S_AXI_RREADY) break;
      if (S_AXI_RVALID) S_AXI_RREADY <= 1'b1;
    end
    tmo(k);
    S_AXI_RREADY <= 1'b0;
    chk(S_AXI_RDATA, x);
    chk(S_AXI_RRESP, r);
  endtask : rd

  task automatic settle;
    repeat (3) @(posedge REF_CLK);
  endtask : settle

  task automatic ann(input logic [1:0] p, input logic [7:0] c,
                     input logic l);
    ANNOUNCE <= {1'b1, l, p, c};
    @(posedge REF_CLK);
    ANNOUNCE <= '0;
    settle;
  endtask : ann

  task automatic send(input logic [3:0] t, input logic [1:0] p,
                      input logic [63:0] ts, input logic [63:0] c);
    int k;
    PTP_IN_VALID <= 1'b1;
    PTP_IN <= {t, p, ts, c};
    for (k = 0; k < 50; k++) begin
      @(posedge REF_CLK);
      if (PTP_IN_READY) break;
    end
    tmo(k);
  endtask : send

  function automatic logic [31:0] tx(input logic [2:0] s,
                                     input logic [3:0] q);
    logic [7:0][3:0] t;
    for (int k = 0; k < 8; k++) t[k] = q;
    t[s] = 4'hC;
    return t;
  endfunction : tx

  // Models the timestamp counter and predicts every forwarded message.
  always @(posedge REF_CLK) begin
    cyc <= SRST ? 64'h0 : cyc + 64'h1;
    if (PTP_IN_VALID && PTP_IN_READY && !bc) begin
      e = PTP_IN;
      if (e.msg_type < 4'h2) e.correction = e.correction
        + cyc * `TIME_INC - e.ingress_ts + link;
      exq.push_back(e);
    end
    if (PTP_OUT_VALID && PTP_OUT_READY) chk(PTP_OUT, exq.pop_front());
    if (PTP_TERM_VALID) nterm++;
  end

  initial begin
    {SRST, S_AXI_WSTRB} = {1'b1, 4'hF};
    {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_ARVALID} = '0;
    S_AXI_BREADY = 1'b1;
    {S_AXI_RREADY, PTP_IN_VALID, S_AXI_AWADDR, S_AXI_ARADDR} = '0;
    {S_AXI_WDATA, SRC_FAULT, SRC_HOLDOVER, SSM_RX, ANNOUNCE} = '0;
    {PTP_IN, bc, slow, link} = '0;
    repeat (20) @(posedge REF_CLK);
    SRST <= 1'b0;
    @(posedge REF_CLK);
    rd(`REG_SRC_BASE, 32'h0BB, 2'b00);
    rd(`REG_SSM_TX_EN, 32'hFF, 2'b00);
    rd(`REG_RX_SSM, 32'hCCCC_CCCC, 2'b00);
    rd(8'h40, 32'h0, 2'b10);
    chk(BC_SLAVE_PORT, 4'h0);
    for (i = 0; i < 8; i++) wr(8'h20 + 8'(4 * i), 32'h10B | 32'(i << 4), 0);
    settle;
    chk(REF_SEL, 3'h7);
    chk(SSM_TX_QL, tx(3'h7, `QL_UNKNOWN));
    rd(`REG_STATUS, 32'hFB, 2'b00);
    wr(8'h2C, 32'h101, 2'b00);
    settle;
    chk(REF_SEL, 3'h3);
    wr(8'h34, 32'h151, 2'b00);
    settle;
    chk(REF_SEL, 3'h5);
    chk(SSM_TX_QL, tx(3'h5, `QL_G811));
    SRC_FAULT <= 8'h20;
    settle;
    chk(REF_SEL, 3'h3);
    rd(`REG_QL_STATUS, 32'hBBDB_1BBB, 2'b00);
    wr(8'h28, 32'h1FD, 2'b00);
    rd(8'h28, 32'h1FB, 2'b00);
    wr(`REG_SSM_CAPABLE, 32'hFB, 2'b00);
    wr(8'h28, 32'h1F0, 2'b00);
    rd(8'h28, 32'h1FB, 2'b00);
    wr(`REG_STATUS, 32'h0, 2'b10);
    wr(8'h30, 32'h100, 2'b00);
    SSM_RX <= {1'b1, 3'h4, `QL_SSU_A};
    @(posedge REF_CLK);
    SSM_RX <= '0;
    rd(`REG_RX_SSM, 32'hCCC2_CCCC, 2'b00);
    SRC_FAULT <= 8'h28;
    settle;
    chk(REF_SEL, 3'h4);
    rd(`REG_STATUS, 32'hC2, 2'b00);
    chk(SSM_TX_QL, tx(3'h4, `QL_SSU_A));
    SRC_FAULT <= 8'h38;
    settle;
    chk(REF_SEL, 3'h2);
    wr(`REG_CTRL, 32'h2, 2'b00);
    SRC_HOLDOVER <= 8'h04;
    settle;
    chk(REF_SEL, 3'h7);
    rd(`REG_QL_STATUS, 32'hBBDD_DCBB, 2'b00);
    SRC_FAULT <= 8'hFF;
    settle;
    chk(REF_VALID, 1'b0);
    chk(SSM_TX_QL, 32'hCCCC_CCCC);
    SRC_FAULT <= 8'h00;
    SRC_HOLDOVER <= 8'h00;
    wr(`REG_CTRL, 32'h0, 2'b00);
    wr(`REG_SSM_TX_EN, 32'h0F, 2'b00);
    chk(SSM_TX_EN, 8'h0F);
    link = 64'h3_0000;
    wr(`REG_LINK_DELAY, 32'h3_0000, 2'b00);
    for (i = 0; i < 8; i++) begin
      slow <= (i > 3);
      send(4'(i % 3), 2'(i), 64'(i) * 64'h100, 64'h5000 + 64'(i));
    end
    PTP_IN_VALID <= 1'b0;
    for (i = 0; i < 50 && beats != 16'd8; i++) @(posedge REF_CLK);
    tmo(i);
    rd(`REG_TC_COUNT, 32'h6, 2'b00);
    wr(`REG_CTRL, 32'h1, 2'b00);
    bc = 1'b1;
    chk(BC_MCAST_EN, 1'b1);
    chk(BC_DEST_MAC[40], 1'b1);
    ann(2'h2, 8'h10, 1'b0);
    ann(2'h1, 8'h20, 1'b0);
    chk(BC_SLAVE_PORT, 4'h4);
    chk(BC_MASTER_PORTS, 4'hB);
    ann(2'h1, 8'h05, 1'b0);
    chk(BC_SLAVE_PORT, 4'h2);
    ann(2'h1, 8'h05, 1'b1);
    chk(BC_SLAVE_PORT, 4'h4);
    send(4'h0, 2'h2, 64'h0, 64'h0);
    send(4'h0, 2'h0, 64'h0, 64'h0);
    PTP_IN_VALID <= 1'b0;
    settle;
    chk(nterm, 1);
    chk(beats, 16'd8);
    wr(`REG_CTRL, 32'h0, 2'b00);
    bc = 1'b0;
    settle;
    chk(BC_SLAVE_PORT, 4'h0);
    close_out;
  end
endmodule : tb_ptp_sync_source_select
`default_nettype wire

// file: verilog/ptp_sync_source_select.sv
// Summary of operation
// R01: End-to-end transparent clock corrects event packets.
// R02: Sync and Delay_Req get residency added.
// R03: Residency covers radio link and processing.
// R04: Transparent mode only forwards, no clock role.
// R05: Boundary mode: four ports, one slave.
// R06: Boundary mode terminates flow on slave port.
// R07: Automatic master selection picks new grandmaster.
// R08: Boundary frames use multicast Ethernet.
// R09: Phase from PTP, frequency from SyncE.
// R10: Fixed quality, failure on interface fault.
// R11: Automatic quality from received SSMs.
// R12: Node quality equals selected source quality.
// R13: Node quality sent on radio interfaces.
// R14: Best quality wins, priority breaks ties.
// R15: Do-not-use sent toward active source.
// R16: Quality ranking fixed, automatic highest.
// R17: Failure not configurable; auto needs SSM.
// R18: Optional do-not-use for holdover interfaces.
// R19: Qualities, received SSMs, node quality readable.
// R20: Operator gives PTP traffic top priority.
// R21: Up to eight sources, one active.
// R22: Correction is scaled ns, 64-bit add.
`include "ptp_sync_map.svh"
`timescale 1ns/1ps
`default_nettype none

module ptp_sync_source_select (
  input  wire logic                     REF_CLK,
  input  wire logic                     SRST,
  input  wire logic [7:0]               S_AXI_AWADDR,
  input  wire logic                     S_AXI_AWVALID,
  output logic                          S_AXI_AWREADY,
  input  wire logic [31:0]              S_AXI_WDATA,
  input  wire logic [3:0]               S_AXI_WSTRB,
  input  wire logic                     S_AXI_WVALID,
  output logic                          S_AXI_WREADY,
  output logic [1:0]                    S_AXI_BRESP,
  output logic                          S_AXI_BVALID,
  input  wire logic                     S_AXI_BREADY,
  input  wire logic [7:0]               S_AXI_ARADDR,
  input  wire logic                     S_AXI_ARVALID,
  output logic                          S_AXI_ARREADY,
  output logic [31:0]                   S_AXI_RDATA,
  output logic [1:0]                    S_AXI_RRESP,
  output logic                          S_AXI_RVALID,
  input  wire logic                     S_AXI_RREADY,
  input  wire logic [7:0]               SRC_FAULT,
  input  wire logic [7:0]               SRC_HOLDOVER,
  input  wire ptp_sync_pkg::ssm_rx_t    SSM_RX,
  output logic [7:0][3:0]               SSM_TX_QL,
  output logic [7:0]                    SSM_TX_EN,
  output logic [2:0]                    REF_SEL,
  output logic                          REF_VALID,
  input  wire logic                     PTP_IN_VALID,
  output logic                          PTP_IN_READY,
  input  wire ptp_sync_pkg::ptp_desc_t  PTP_IN,
  output logic                          PTP_OUT_VALID,
  input  wire logic                     PTP_OUT_READY,
  output ptp_sync_pkg::ptp_desc_t       PTP_OUT,
  output logic                          PTP_TERM_VALID,
  input  wire ptp_sync_pkg::announce_t  ANNOUNCE,
  output logic [3:0]                    BC_SLAVE_PORT,
  output logic [3:0]                    BC_MASTER_PORTS,
  output logic                          BC_MCAST_EN,
  output logic [47:0]                   BC_DEST_MAC
);

  logic [1:0]        ctrl_q;
  logic [31:0]       link_delay_q;
  logic [7:0]        ssm_tx_en_q;
  logic [7:0]        ssm_cap_q;
  logic [7:0][8:0]   src_cfg_q;
  logic [7:0][3:0]   rx_ssm_q;
  logic [7:0][3:0]   status_ql;
  logic [31:0]       tc_count_q;
  logic [63:0]       time_q;
  logic              bc_mode;
  logic              aw_q;
  logic              w_q;
  logic [7:0]        awaddr_q;
  logic [31:0]       wdata_q;
  logic [3:0]        wstrb_q;
  logic              do_write;
  logic [31:0]       wmerge;
  logic [2:0]        widx;
  logic              wsrc;
  logic              wmap;
  logic [31:0]       rdata_d;
  logic              rmap;
  logic              best_valid;
  logic [2:0]        best_idx;
  logic [3:0]        best_ql;
  logic [3:0]        best_pri;
  logic              active_valid_q;
  logic [2:0]        active_idx_q;
  logic [3:0]        node_ql_q;
  logic [3:0]        ann_valid_q;
  logic [3:0][7:0]   ann_class_q;
  logic              gm_valid;
  logic [1:0]        gm_port;
  logic              gm_valid_q;
  logic [1:0]        gm_port_q;
  logic              ptp_take;
  logic              is_event;
  logic [63:0]       residency;
  logic [63:0]       corr_d;

  assign bc_mode = ctrl_q[`CTRL_BC_MODE];

  // AXI4-Lite write path: address and data taken in either order.
  assign S_AXI_AWREADY = !aw_q && !S_AXI_BVALID;
  assign S_AXI_WREADY  = !w_q && !S_AXI_BVALID;
  assign do_write      = aw_q && w_q && !S_AXI_BVALID;
  assign widx          = 3'(awaddr_q[4:2]);
  assign wsrc          = awaddr_q >= `REG_SRC_BASE &&
                         awaddr_q <= `REG_SRC_LAST;

  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      aw_q     <= 1'b0;
      w_q      <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q  <= 32'h0000_0000;
      wstrb_q  <= 4'h0;
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_q     <= 1'b1;
        awaddr_q <= {S_AXI_AWADDR[7:2], 2'b00};
      end else if (do_write) begin
        aw_q <= 1'b0;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_q     <= 1'b1;
        wdata_q <= S_AXI_WDATA;
        wstrb_q <= S_AXI_WSTRB;
      end else if (do_write) begin
        w_q <= 1'b0;
      end
    end
  end

  always_comb begin
    wmerge = 32'h0000_0000;
    case (awaddr_q)
      `REG_CTRL:        wmerge = {30'h0000_0000, ctrl_q};
      `REG_LINK_DELAY:  wmerge = link_delay_q;
      `REG_SSM_TX_EN:   wmerge = {24'h00_0000, ssm_tx_en_q};
      `REG_SSM_CAPABLE: wmerge = {24'h00_0000, ssm_cap_q};
      default:          wmerge = wsrc ? {23'h00_0000, src_cfg_q[widx]}
                                      : 32'h0000_0000;
    endcase
    for (int b = 0; b < 4; b++) begin
      if (wstrb_q[b]) begin
        wmerge[b*8 +: 8] = wdata_q[b*8 +: 8];
      end
    end
  end

  assign wmap = wsrc || awaddr_q == `REG_CTRL ||
                awaddr_q == `REG_LINK_DELAY ||
                awaddr_q == `REG_SSM_TX_EN ||
                awaddr_q == `REG_SSM_CAPABLE;

  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP  <= 2'b00;
    end else if (do_write) begin
      S_AXI_BVALID <= 1'b1;
      S_AXI_BRESP  <= wmap ? 2'b00 : 2'b10;
    end else if (S_AXI_BREADY) begin
      S_AXI_BVALID <= 1'b0;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      ctrl_q       <= 2'b00;
      link_delay_q <= `RST_LINK_DELAY;
      ssm_tx_en_q  <= `RST_SSM_TX_EN;
      ssm_cap_q    <= `RST_SSM_CAP;
    end else if (do_write) begin
      case (awaddr_q)
        `REG_CTRL:        ctrl_q       <= wmerge[1:0];
        `REG_LINK_DELAY:  link_delay_q <= wmerge;
        `REG_SSM_TX_EN:   ssm_tx_en_q  <= wmerge[7:0];
        `REG_SSM_CAPABLE: ssm_cap_q    <= wmerge[7:0];
        default: ;
      endcase
    end
  end

  // Per-source configuration, received SSM and quality status.
  generate
    for (genvar g = 0; g < 8; g++) begin : src
      logic [3:0] new_ql;
      logic       cfg_auto;
      assign new_ql   = wmerge[`SRC_QL_LSB +: 4];
      assign cfg_auto = src_cfg_q[g][`SRC_QL_LSB +: 4] == `QL_AUTO &&
                        ssm_cap_q[g];

      always_ff @(posedge REF_CLK) begin
        if (SRST) begin
          src_cfg_q[g] <= `RST_SRC_CFG;
        end else if (do_write && wsrc && widx == 3'(g)) begin
          src_cfg_q[g][8:4] <= wmerge[8:4];
          if (new_ql < `QL_FAILURE &&
              (new_ql != `QL_AUTO || ssm_cap_q[g])) begin // R17
            src_cfg_q[g][`SRC_QL_LSB +: 4] <= new_ql;
          end
        end
      end

      always_ff @(posedge REF_CLK) begin
        if (SRST) begin
          rx_ssm_q[g] <= `QL_NO_USE;
        end else if (SSM_RX.valid && SSM_RX.port == 3'(g)) begin
          rx_ssm_q[g] <= SSM_RX.ql; // R11
        end
      end

      always_comb begin
        if (SRC_FAULT[g]) begin
          status_ql[g] = `QL_FAILURE; // R10 R11
        end else if (SRC_HOLDOVER[g] && ctrl_q[`CTRL_HOLD_NO_USE]) begin
          status_ql[g] = `QL_NO_USE; // R18
        end else if (cfg_auto) begin
          status_ql[g] = (rx_ssm_q[g] == `QL_AUTO ||
                          rx_ssm_q[g] > `QL_NO_USE) ? `QL_NO_USE
                                                 : rx_ssm_q[g]; // R11
        end else begin
          status_ql[g] = src_cfg_q[g][`SRC_QL_LSB +: 4]; // R10
        end
      end
    end
  endgenerate

  // Lower code ranks higher; larger priority wins a tie.
  always_comb begin
    best_valid = 1'b0;
    best_idx   = 3'h0;
    best_ql    = `QL_FAILURE;
    best_pri   = 4'h0;
    for (int i = 0; i < 8; i++) begin
      if (src_cfg_q[i][`SRC_EN_BIT] && status_ql[i] < `QL_NO_USE) begin // R21
        if (!best_valid || status_ql[i] < best_ql ||
            (status_ql[i] == best_ql &&
             src_cfg_q[i][`SRC_PRI_LSB +: 4] > best_pri)) begin // R14 R16
          best_valid = 1'b1;
          best_idx   = 3'(i);
          best_ql    = status_ql[i];
          best_pri   = src_cfg_q[i][`SRC_PRI_LSB +: 4];
        end
      end
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      active_valid_q <= 1'b0;
      active_idx_q   <= 3'h0;
      node_ql_q      <= `QL_FAILURE;
    end else begin
      active_valid_q <= best_valid; // R21
      active_idx_q   <= best_idx;
      node_ql_q      <= best_ql; // R12
    end
  end

  assign REF_SEL   = active_idx_q;
  assign REF_VALID = active_valid_q;
  assign SSM_TX_EN = ssm_tx_en_q; // R13

  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      SSM_TX_QL <= {8{`QL_NO_USE}};
    end else begin
      for (int i = 0; i < 8; i++) begin
        if (active_valid_q && active_idx_q == 3'(i)) begin
          SSM_TX_QL[i] <= `QL_NO_USE; // R15
        end else if (node_ql_q >= `QL_NO_USE) begin
          SSM_TX_QL[i] <= `QL_NO_USE;
        end else begin
          SSM_TX_QL[i] <= node_ql_q; // R13
        end
      end
    end
  end

  // Boundary clock grandmaster election over four ports.
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      ann_valid_q <= 4'h0;
      ann_class_q <= {4{8'hFF}};
    end else if (ANNOUNCE.valid) begin
      ann_valid_q[ANNOUNCE.port] <= !ANNOUNCE.lost; // R07
      ann_class_q[ANNOUNCE.port] <= ANNOUNCE.clock_class;
    end
  end

  always_comb begin
    gm_valid = 1'b0;
    gm_port  = 2'h0;
    for (int p = 0; p < 4; p++) begin
      if (ann_valid_q[p] &&
          (!gm_valid || ann_class_q[p] < ann_class_q[gm_port])) begin // R07
        gm_valid = 1'b1;
        gm_port  = 2'(p);
      end
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      gm_valid_q      <= 1'b0;
      gm_port_q       <= 2'h0;
      BC_SLAVE_PORT   <= 4'h0;
      BC_MASTER_PORTS <= 4'h0;
    end else begin
      gm_valid_q <= gm_valid;
      gm_port_q  <= gm_port;
      if (bc_mode && gm_valid) begin
        BC_SLAVE_PORT   <= 4'h1 << gm_port; // R05
        BC_MASTER_PORTS <= ~(4'h1 << gm_port); // R05
      end else begin
        BC_SLAVE_PORT   <= 4'h0; // R04
        BC_MASTER_PORTS <= 4'h0;
      end
    end
  end

  assign BC_MCAST_EN = bc_mode; // R08
  assign BC_DEST_MAC = `PTP_MCAST_MAC; // R08

  // Transparent clock datapath with free-running scaled time.
  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      time_q <= 64'h0000_0000_0000_0000;
    end else begin
      time_q <= time_q + `TIME_INC; // R22
    end
  end

  assign PTP_IN_READY = !PTP_OUT_VALID || PTP_OUT_READY;
  assign ptp_take     = PTP_IN_VALID && PTP_IN_READY;
  assign is_event     = PTP_IN.msg_type < 4'h2; // R02
  assign residency    = (time_q - PTP_IN.ingress_ts) +
                        64'(link_delay_q); // R03
  assign corr_d       = PTP_IN.correction +
                        (is_event ? residency : 64'h0); // R01 R22

  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      PTP_OUT_VALID  <= 1'b0;
      PTP_OUT        <= '0;
      PTP_TERM_VALID <= 1'b0;
      tc_count_q     <= 32'h0000_0000;
    end else begin
      PTP_TERM_VALID <= 1'b0;
      if (ptp_take && bc_mode) begin
        PTP_OUT_VALID  <= 1'b0; // R06
        PTP_OUT        <= PTP_IN;
        PTP_TERM_VALID <= gm_valid_q && PTP_IN.port == gm_port_q; // R06 R09
      end else if (ptp_take) begin
        PTP_OUT_VALID         <= 1'b1; // R04
        PTP_OUT               <= PTP_IN;
        PTP_OUT.correction    <= corr_d; // R02
        if (is_event) begin
          tc_count_q <= tc_count_q + 32'h0000_0001;
        end
      end else if (PTP_OUT_READY) begin
        PTP_OUT_VALID <= 1'b0;
      end
    end
  end

  // AXI4-Lite read path.
  assign S_AXI_ARREADY = !S_AXI_RVALID;
  assign rmap = S_AXI_ARADDR <= `REG_SRC_LAST;

  always_comb begin
    rdata_d = 32'h0000_0000;
    case ({S_AXI_ARADDR[7:2], 2'b00})
      `REG_CTRL:        rdata_d = {30'h0000_0000, ctrl_q};
      `REG_LINK_DELAY:  rdata_d = link_delay_q;
      `REG_SSM_TX_EN:   rdata_d = {24'h00_0000, ssm_tx_en_q};
      `REG_SSM_CAPABLE: rdata_d = {24'h00_0000, ssm_cap_q};
      `REG_STATUS:      rdata_d = {21'h00_0000, gm_valid_q, gm_port_q,
                                   active_valid_q, active_idx_q,
                                   node_ql_q}; // R19
      `REG_QL_STATUS:   rdata_d = status_ql; // R19
      `REG_RX_SSM:      rdata_d = rx_ssm_q; // R19
      `REG_TC_COUNT:    rdata_d = tc_count_q;
      default:          rdata_d = rmap ? {23'h00_0000,
                                          src_cfg_q[S_AXI_ARADDR[4:2]]}
                                       : 32'h0000_0000;
    endcase
  end

  always_ff @(posedge REF_CLK) begin
    if (SRST) begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA  <= 32'h0000_0000;
      S_AXI_RRESP  <= 2'b00;
    end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      S_AXI_RVALID <= 1'b1;
      S_AXI_RDATA  <= rdata_d;
      S_AXI_RRESP  <= rmap ? 2'b00 : 2'b10;
    end else if (S_AXI_RREADY) begin
      S_AXI_RVALID <= 1'b0;
    end
  end

endmodule : ptp_sync_source_select

`default_nettype wire
